// [core/ref_flag_logic.sv]
/*
  receiver status qualification: error and auto-source cause selection,
  release wait on preamble-b count, rate limits, non-pcm definition,
  compressed-cd sync qualification, crystal oscillator and clock output.
  assumes receiver status inputs are synchronous to clk, preamble_b and the
  sync word strobes are one-cycle pulses, and xtal_tick marks each
  crystal clock period as a one-cycle enable.
*/
`timescale 1ns/1ps
`default_nettype none
module ref_flag_logic (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // release wait code from the shared settings register
  input wire logic [1:0] error_release_wait,
  // receiver status
  input wire logic pll_locked,
  input wire logic rate_changed,
  input wire logic [11:0] rate_measure,
  input wire logic validity_flag,
  input wire logic parity_error,
  input wire logic preamble_b,
  input wire logic cs_bit1_detect,
  input wire logic burst_preamble_detect,
  input wire logic sync_word16_detect,
  input wire logic sync_word14_detect,
  input wire logic sync_period_mark,
  input wire logic crystal_power_down,
  input wire logic xtal_tick,
  // flags and controls
  output logic error_flag,
  output logic clock_change_strobe,
  output logic non_pcm_flag_pin,
  output logic cd_sync_flag,
  output logic auto_use_adc,
  output logic adc_out_clock_sel,
  output logic osc_run,
  output logic buffered_crystal_clock_out
);
  logic [7:0] osc_reg, err_reg, auto_reg, rate_reg, non_pcm_flag_pin_reg, sync_reg, irq_reg;
  ref_pkg::rel_state_t rel_reg;
  logic [5:0] wcnt_reg;
  logic [2:0] div_reg;
  logic [2:0] per_reg;
  logic cs1_d_reg, cdsync_reg;
  logic range_bad, nominal_bad, rate_fault, non_pcm_flag_pin_raw, cs1_term, err_now, trig;
  logic [5:0] wait_len;
  logic [2:0] per_need;

  function automatic logic near_rate(input logic [11:0] r, input logic [11:0] n);
    logic [15:0] tol;
    tol = 16'(n / 12'h032);
    return (16'(r) + tol >= 16'(n)) && (16'(r) <= 16'(n) + tol);
  endfunction

  // register writes, separate stores per selection
  always_ff @(posedge clk) begin
    if (rst) begin
      osc_reg <= ref_pkg::OSC_CTRL_RST;
      err_reg <= ref_pkg::ERR_SEL_RST;
      auto_reg <= ref_pkg::AUTO_SEL_RST;
      rate_reg <= ref_pkg::RATE_RST;
      non_pcm_flag_pin_reg <= ref_pkg::NON_PCM_FLAG_PIN_DEF_RST;
      sync_reg <= ref_pkg::SYNC_SET_RST;
      irq_reg <= ref_pkg::IRQ0_MASK_RST;
    end else if (reg_wr) begin
      if (reg_addr == ref_pkg::OSC_CTRL_ADDR) begin
        osc_reg <= reg_wdata & 8'h9c;
      end else if (reg_addr == ref_pkg::ERR_SEL_ADDR) begin
        err_reg <= reg_wdata & 8'h3f;
      end else if (reg_addr == ref_pkg::AUTO_SEL_ADDR) begin
        auto_reg <= reg_wdata;
      end else if (reg_addr == ref_pkg::RATE_ADDR) begin
        rate_reg <= reg_wdata & 8'hdf;
      end else if (reg_addr == ref_pkg::NON_PCM_FLAG_PIN_DEF_ADDR) begin
        non_pcm_flag_pin_reg <= reg_wdata & 8'h37;
      end else if (reg_addr == ref_pkg::SYNC_SET_ADDR) begin
        sync_reg <= reg_wdata & 8'h0f;
      end else if (reg_addr == ref_pkg::IRQ0_MASK_ADDR) begin
        irq_reg <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == ref_pkg::OSC_CTRL_ADDR) begin
      reg_rdata <= osc_reg;
    end else if (reg_addr == ref_pkg::ERR_SEL_ADDR) begin
      reg_rdata <= err_reg;
    end else if (reg_addr == ref_pkg::AUTO_SEL_ADDR) begin
      reg_rdata <= auto_reg;
    end else if (reg_addr == ref_pkg::RATE_ADDR) begin
      reg_rdata <= rate_reg;
    end else if (reg_addr == ref_pkg::NON_PCM_FLAG_PIN_DEF_ADDR) begin
      reg_rdata <= non_pcm_flag_pin_reg;
    end else if (reg_addr == ref_pkg::SYNC_SET_ADDR) begin
      reg_rdata <= sync_reg;
    end else if (reg_addr == ref_pkg::IRQ0_MASK_ADDR) begin
      reg_rdata <= irq_reg;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // acceptable rate range
  always_comb begin
    range_bad = 1'b0;
    case (rate_reg[ref_pkg::HI_LMT_LSB +: 2])
      2'b01: range_bad = rate_measure > ref_pkg::HI_54;
      2'b10: range_bad = rate_measure > ref_pkg::HI_108;
      2'b11: range_bad = rate_measure > ref_pkg::HI_216;
      default: range_bad = 1'b0;
    endcase
    case (rate_reg[ref_pkg::LO_LMT_LSB +: 2])
      2'b01: range_bad = range_bad | (rate_measure < ref_pkg::LO_7);
      2'b10: range_bad = range_bad | (rate_measure < ref_pkg::LO_14);
      2'b11: range_bad = range_bad | (rate_measure < ref_pkg::LO_28);
      default: range_bad = range_bad;
    endcase
  end

  // nominal rates in 0.1 khz units
  always_comb begin
    nominal_bad = !(near_rate(rate_measure, 12'h050) || near_rate(rate_measure, 12'h06e)
      || near_rate(rate_measure, 12'h078) || near_rate(rate_measure, 12'h0a0)
      || near_rate(rate_measure, 12'h0dc) || near_rate(rate_measure, 12'h0f0)
      || near_rate(rate_measure, 12'h140) || near_rate(rate_measure, 12'h1b9)
      || near_rate(rate_measure, 12'h1e0) || near_rate(rate_measure, ref_pkg::RATE_64K)
      || near_rate(rate_measure, 12'h372) || near_rate(rate_measure, 12'h3c0)
      || near_rate(rate_measure, ref_pkg::RATE_128K) || near_rate(rate_measure, 12'h6e4)
      || near_rate(rate_measure, 12'h780));
    if (rate_reg[ref_pkg::MASK_TOP_BIT] && near_rate(rate_measure, ref_pkg::RATE_128K)) begin
      nominal_bad = 1'b1;
    end
    if (rate_reg[ref_pkg::MASK_MID_BIT] && near_rate(rate_measure, ref_pkg::RATE_64K)) begin
      nominal_bad = 1'b1;
    end
    rate_fault = range_bad | (rate_reg[ref_pkg::NOMINAL_BIT] & nominal_bad);
  end

  // non-pcm definition
  always_comb begin
    cs1_term = non_pcm_flag_pin_reg[ref_pkg::CS1_PULSE_BIT] ? (cs_bit1_detect & ~cs1_d_reg)
      : cs_bit1_detect;
    non_pcm_flag_pin_raw = (non_pcm_flag_pin_reg[ref_pkg::CS1_SEL_BIT] & cs1_term)
      | (non_pcm_flag_pin_reg[ref_pkg::PREAMBLE_SEL_BIT] & burst_preamble_detect)
      | (non_pcm_flag_pin_reg[ref_pkg::CD_SYNC_SEL_BIT] & cdsync_reg);
    err_now = (err_reg[ref_pkg::SEL_RATE_CHG] & rate_changed)
      | (err_reg[ref_pkg::SEL_RATE_LMT] & rate_fault)
      | (err_reg[ref_pkg::SEL_NON_PCM_FLAG_PIN] & non_pcm_flag_pin_raw)
      | (err_reg[ref_pkg::SEL_VALID] & validity_flag)
      | (err_reg[ref_pkg::SEL_PARITY] & parity_error)
      | (err_reg[ref_pkg::SEL_UNLOCK] & ~pll_locked);
    trig = ~pll_locked | rate_changed | rate_fault;
    case (error_release_wait)
      2'b01: wait_len = ref_pkg::WAIT_12;
      2'b10: wait_len = ref_pkg::WAIT_6;
      2'b11: wait_len = ref_pkg::WAIT_3;
      default: wait_len = ref_pkg::WAIT_48;
    endcase
    case (sync_reg[ref_pkg::PERIOD_LSB +: 2])
      2'b01: per_need = ref_pkg::PER_1;
      2'b10: per_need = ref_pkg::PER_2;
      2'b11: per_need = ref_pkg::PER_4;
      default: per_need = ref_pkg::PER_0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cs1_d_reg <= 1'b0;
    end else begin
      cs1_d_reg <= cs_bit1_detect;
    end
  end

  // compressed-cd sync word qualification
  always_ff @(posedge clk) begin
    if (rst) begin
      per_reg <= 3'h0;
      cdsync_reg <= 1'b0;
    end else if ((sync_reg[ref_pkg::SYNC16_BIT] & sync_word16_detect)
        | (sync_reg[ref_pkg::SYNC14_BIT] & sync_word14_detect)) begin
      if (per_reg >= per_need) begin
        cdsync_reg <= 1'b1;
      end
    end else if (sync_period_mark) begin
      if (per_reg < ref_pkg::PER_4) begin
        per_reg <= per_reg + 3'h1;
      end
    end else if (~pll_locked) begin
      per_reg <= 3'h0;
      cdsync_reg <= 1'b0;
    end
  end

  // release wait machine
  always_ff @(posedge clk) begin
    if (rst) begin
      rel_reg <= ref_pkg::REL_IDLE;
      wcnt_reg <= 6'h00;
    end else begin
      case (rel_reg)
        ref_pkg::REL_IDLE: begin
          if (trig) begin
            rel_reg <= ref_pkg::REL_HOLD;
          end
        end
        ref_pkg::REL_HOLD: begin
          wcnt_reg <= 6'h00;
          if (!trig && !err_now) begin
            rel_reg <= ref_pkg::REL_WAIT;
          end
        end
        ref_pkg::REL_WAIT: begin
          if (trig || err_now) begin
            rel_reg <= ref_pkg::REL_HOLD;
          end else if (preamble_b) begin
            if (wcnt_reg + 6'h01 >= wait_len) begin
              rel_reg <= ref_pkg::REL_IDLE;
            end
            wcnt_reg <= wcnt_reg + 6'h01;
          end
        end
        default: rel_reg <= ref_pkg::REL_IDLE;
      endcase
    end
  end

  // flag outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      error_flag <= 1'b1;
      clock_change_strobe <= 1'b1;
      non_pcm_flag_pin <= 1'b0;
      cd_sync_flag <= 1'b0;
      auto_use_adc <= 1'b1;
      adc_out_clock_sel <= 1'b0;
    end else begin
      error_flag <= err_now | (rel_reg != ref_pkg::REL_IDLE);
      clock_change_strobe <= trig | (rel_reg != ref_pkg::REL_IDLE);
      non_pcm_flag_pin <= non_pcm_flag_pin_raw ^ non_pcm_flag_pin_reg[ref_pkg::NON_PCM_FLAG_PIN_POL_BIT];
      cd_sync_flag <= cdsync_reg & non_pcm_flag_pin_reg[ref_pkg::CD_SYNC_SEL_BIT];
      auto_use_adc <= (auto_reg[ref_pkg::AUTO_ERR_BIT] & (err_now
          | (rel_reg != ref_pkg::REL_IDLE)))
        | (auto_reg[ref_pkg::SEL_RATE_LMT] & rate_fault)
        | (auto_reg[ref_pkg::SEL_NON_PCM_FLAG_PIN] & non_pcm_flag_pin_raw)
        | (auto_reg[ref_pkg::SEL_VALID] & validity_flag)
        | (auto_reg[ref_pkg::SEL_UNLOCK] & ~pll_locked);
      adc_out_clock_sel <= auto_reg[ref_pkg::ADC_CLK_SEL_BIT];
    end
  end

  // oscillator and divided clock output
  always_ff @(posedge clk) begin
    if (rst) begin
      osc_run <= 1'b1;
      div_reg <= 3'h0;
      buffered_crystal_clock_out <= 1'b0;
    end else begin
      osc_run <= ~crystal_power_down
        & ~(osc_reg[ref_pkg::OSC_AUTO_BIT] & pll_locked);
      if (xtal_tick) begin
        div_reg <= div_reg + 3'h1;
      end
      if (crystal_power_down || !osc_reg[ref_pkg::XCLK_EN_BIT]) begin
        buffered_crystal_clock_out <= 1'b0;
      end else begin
        case (osc_reg[ref_pkg::XCLK_DIV_LSB +: 2])
          2'b01: buffered_crystal_clock_out <= div_reg[0];
          2'b10: buffered_crystal_clock_out <= div_reg[1];
          2'b11: buffered_crystal_clock_out <= div_reg[2];
          default: buffered_crystal_clock_out <= xtal_tick;
        endcase
      end
    end
  end

  a_err_sel_unlock: assert property (@(posedge clk) disable iff (rst)
    (err_reg[ref_pkg::SEL_UNLOCK] && !pll_locked) |=> error_flag)
    else $error("unlock did not raise error");
  a_err_release_hold: assert property (@(posedge clk) disable iff (rst)
    (rel_reg == ref_pkg::REL_WAIT) |=> error_flag)
    else $error("error released during wait");
  a_osc_pd_wins: assert property (@(posedge clk) disable iff (rst)
    crystal_power_down |=> !osc_run && !buffered_crystal_clock_out)
    else $error("power-down did not stop oscillator");
  a_osc_auto_stop: assert property (@(posedge clk) disable iff (rst)
    (osc_reg[ref_pkg::OSC_AUTO_BIT] && pll_locked) |=> !osc_run)
    else $error("oscillator ran while locked in auto");
  a_clk_out_mute: assert property (@(posedge clk) disable iff (rst)
    !osc_reg[ref_pkg::XCLK_EN_BIT] |=> !buffered_crystal_clock_out)
    else $error("clock out not muted");
  a_auto_unlock_adc: assert property (@(posedge clk) disable iff (rst)
    (auto_reg[ref_pkg::SEL_UNLOCK] && !pll_locked) |=> auto_use_adc)
    else $error("auto selector kept receiver when unlocked");
  a_cd_flag_gate: assert property (@(posedge clk) disable iff (rst)
    !non_pcm_flag_pin_reg[ref_pkg::CD_SYNC_SEL_BIT] |=> !cd_sync_flag)
    else $error("cd sync flag shown while unselected");
  a_clock_change_strobe_follows: assert property (@(posedge clk) disable iff (rst)
    trig |=> clock_change_strobe)
    else $error("clock change strobe missed");
  a_err_parity_sel: assert property (@(posedge clk) disable iff (rst)
    (err_reg[ref_pkg::SEL_PARITY] && parity_error) |=> error_flag)
    else $error("parity did not raise error");
  a_err_valid_sel: assert property (@(posedge clk) disable iff (rst)
    (err_reg[ref_pkg::SEL_VALID] && validity_flag) |=> error_flag)
    else $error("validity did not raise error");
  a_err_wait_restart: assert property (@(posedge clk) disable iff (rst)
    (rel_reg == ref_pkg::REL_WAIT && (trig || err_now)) |=> (rel_reg == ref_pkg::REL_HOLD))
    else $error("new cause did not restart wait");
  a_auto_valid_sel: assert property (@(posedge clk) disable iff (rst)
    (auto_reg[ref_pkg::SEL_VALID] && validity_flag) |=> auto_use_adc)
    else $error("validity did not pick adc");
  a_auto_err_link: assert property (@(posedge clk) disable iff (rst)
    (auto_reg[ref_pkg::AUTO_ERR_BIT] && err_now) |=> auto_use_adc)
    else $error("composite error did not pick adc");
  a_rate_hi_limit: assert property (@(posedge clk) disable iff (rst)
    (rate_reg[ref_pkg::HI_LMT_LSB +: 2] == 2'b01 && rate_measure > ref_pkg::HI_54)
    |-> rate_fault)
    else $error("rate above upper limit accepted");
  a_rate_lo_limit: assert property (@(posedge clk) disable iff (rst)
    (rate_reg[ref_pkg::LO_LMT_LSB +: 2] == 2'b11 && rate_measure < ref_pkg::LO_28)
    |-> rate_fault)
    else $error("rate below lower limit accepted");
  a_rate_mask_top: assert property (@(posedge clk) disable iff (rst)
    (rate_reg[ref_pkg::NOMINAL_BIT] && rate_reg[ref_pkg::MASK_TOP_BIT]
    && rate_measure == ref_pkg::RATE_128K) |-> rate_fault)
    else $error("masked rate accepted");
  a_rate_no_limit: assert property (@(posedge clk) disable iff (rst)
    (!rate_reg[ref_pkg::NOMINAL_BIT] && rate_reg[ref_pkg::HI_LMT_LSB +: 2] == 2'b00
    && rate_reg[ref_pkg::LO_LMT_LSB +: 2] == 2'b00) |-> !rate_fault)
    else $error("rate refused with no limit");
  a_non_pcm_flag_pin_pol_high: assert property (@(posedge clk) disable iff (rst)
    (!non_pcm_flag_pin_reg[ref_pkg::NON_PCM_FLAG_PIN_POL_BIT] && !non_pcm_flag_pin_raw) |=> !non_pcm_flag_pin)
    else $error("non-pcm pin high for pcm");
  a_non_pcm_flag_pin_pol_low: assert property (@(posedge clk) disable iff (rst)
    (non_pcm_flag_pin_reg[ref_pkg::NON_PCM_FLAG_PIN_POL_BIT] && non_pcm_flag_pin_raw) |=> !non_pcm_flag_pin)
    else $error("inverted non-pcm pin not low");
  a_cd_period_need: assert property (@(posedge clk) disable iff (rst)
    (!cdsync_reg && per_reg < per_need) |=> !cdsync_reg)
    else $error("sync flag set before periods");
  c_release: cover property (@(posedge clk) disable iff (rst)
    (rel_reg == ref_pkg::REL_WAIT) ##1 (rel_reg == ref_pkg::REL_IDLE));
  c_cd_sync: cover property (@(posedge clk) disable iff (rst) cd_sync_flag);
  c_auto_adc: cover property (@(posedge clk) disable iff (rst) $rose(auto_use_adc));
  c_rate_fault: cover property (@(posedge clk) disable iff (rst) $rose(rate_fault));
  c_cd_period: cover property (@(posedge clk) disable iff (rst)
    (per_need != ref_pkg::PER_0) && $rose(cdsync_reg));
endmodule
`default_nettype wire

// [core/ref_pkg.sv]
/*
  constants for the receiver error flag logic: register offsets, field
  positions, reset values and code tables.
  assumes a byte-wide register port driven by the host control interface.
*/
package ref_pkg;
  localparam logic [7:0] OSC_CTRL_ADDR = 8'h24;
  localparam logic [7:0] ERR_SEL_ADDR = 8'h25;
  localparam logic [7:0] AUTO_SEL_ADDR = 8'h26;
  localparam logic [7:0] RATE_ADDR = 8'h27;
  localparam logic [7:0] NON_PCM_FLAG_PIN_DEF_ADDR = 8'h28;
  localparam logic [7:0] SYNC_SET_ADDR = 8'h29;
  localparam logic [7:0] IRQ0_MASK_ADDR = 8'h2a;
  localparam logic [7:0] OSC_CTRL_RST = 8'h00;
  localparam logic [7:0] ERR_SEL_RST = 8'h01;
  localparam logic [7:0] AUTO_SEL_RST = 8'h01;
  localparam logic [7:0] RATE_RST = 8'h00;
  localparam logic [7:0] NON_PCM_FLAG_PIN_DEF_RST = 8'h03;
  localparam logic [7:0] SYNC_SET_RST = 8'h0c;
  localparam logic [7:0] IRQ0_MASK_RST = 8'hff;
  localparam logic [7:0] ERROR_RELEASE_WAIT_RST = 8'h00;
  // oscillator control fields
  localparam int OSC_AUTO_BIT = 7;
  localparam int XCLK_EN_BIT = 4;
  localparam int XCLK_DIV_LSB = 2;
  // cause select fields (error and auto share positions)
  localparam int SEL_RATE_CHG = 5;
  localparam int SEL_RATE_LMT = 4;
  localparam int SEL_NON_PCM_FLAG_PIN = 3;
  localparam int SEL_VALID = 2;
  localparam int SEL_PARITY = 1;
  localparam int SEL_UNLOCK = 0;
  localparam int ADC_CLK_SEL_BIT = 7;
  localparam int AUTO_ERR_BIT = 6;
  // rate range fields
  localparam int MASK_TOP_BIT = 7;
  localparam int MASK_MID_BIT = 6;
  localparam int NOMINAL_BIT = 4;
  localparam int HI_LMT_LSB = 2;
  localparam int LO_LMT_LSB = 0;
  // non-pcm definition fields
  localparam int CS1_PULSE_BIT = 5;
  localparam int NON_PCM_FLAG_PIN_POL_BIT = 4;
  localparam int CD_SYNC_SEL_BIT = 2;
  localparam int PREAMBLE_SEL_BIT = 1;
  localparam int CS1_SEL_BIT = 0;
  // sync detect fields
  localparam int SYNC16_BIT = 3;
  localparam int SYNC14_BIT = 2;
  localparam int PERIOD_LSB = 0;
  // preamble-b counts for release wait codes
  localparam logic [5:0] WAIT_48 = 6'h30;
  localparam logic [5:0] WAIT_12 = 6'h0c;
  localparam logic [5:0] WAIT_6 = 6'h06;
  localparam logic [5:0] WAIT_3 = 6'h03;
  // rate limits in units of 0.1 khz
  localparam logic [11:0] HI_54 = 12'h21c;
  localparam logic [11:0] HI_108 = 12'h438;
  localparam logic [11:0] HI_216 = 12'h870;
  localparam logic [11:0] LO_7 = 12'h046;
  localparam logic [11:0] LO_14 = 12'h08c;
  localparam logic [11:0] LO_28 = 12'h118;
  localparam logic [11:0] RATE_128K = 12'h500;
  localparam logic [11:0] RATE_64K = 12'h280;
  // sync word periods required per code
  localparam logic [2:0] PER_0 = 3'h0;
  localparam logic [2:0] PER_1 = 3'h1;
  localparam logic [2:0] PER_2 = 3'h2;
  localparam logic [2:0] PER_4 = 3'h4;
  typedef enum logic [2:0] {
    REL_IDLE = 3'b001,
    REL_HOLD = 3'b010,
    REL_WAIT = 3'b100
  } rel_state_t;
endpackage

// [bench/ref_src_model.sv]
/*
  source-side model: pll lock, block-start preambles and crystal ticks.
  assumes the bench requests lock and the design gates the crystal.
*/
`timescale 1ns/1ps
`default_nettype none
module ref_src_model #(
  parameter int PRE_GAP = 8,
  parameter int TICK_GAP = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // requests
  input wire logic lock_req,
  input wire logic osc_run,
  // receiver side
  output logic pll_locked = 1'b0,
  output logic preamble_b = 1'b0,
  output logic xtal_tick = 1'b0
);
  int pcnt = 0;
  int tcnt = 0;
  // one preamble pulse per block, only while locked
  always_ff @(posedge clk) begin
    pll_locked <= lock_req & ~rst;
    pcnt <= (rst || !pll_locked || pcnt == PRE_GAP - 1) ? 0 : pcnt + 1;
    preamble_b <= pll_locked && !rst && pcnt == PRE_GAP - 1;
  end
  // crystal ticks only while the oscillator runs
  always_ff @(posedge clk) begin
    tcnt <= (rst || !osc_run || tcnt == TICK_GAP - 1) ? 0 : tcnt + 1;
    xtal_tick <= osc_run && !rst && tcnt == TICK_GAP - 1;
  end
endmodule
`default_nettype wire

// [bench/ref_flag_logic_tb_top.sv]
/*
  self-checking bench for the receiver error flag logic.
  assumes the source model supplies lock, preambles and crystal ticks.
*/
`timescale 1ns/1ps
`default_nettype none
module ref_flag_logic_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic lock_req = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [1:0] error_release_wait = 2'b11;
  logic [11:0] rate_measure = 12'h1e0;
  logic rate_changed = 1'b0, validity_flag = 1'b0, parity_error = 1'b0;
  logic cs_bit1_detect = 1'b0, burst_preamble_detect = 1'b0, crystal_power_down = 1'b0;
  logic sync_word16_detect = 1'b0, sync_word14_detect = 1'b0, sync_period_mark = 1'b0;
  logic [7:0] reg_rdata;
  logic pll_locked, preamble_b, xtal_tick, error_flag, clock_change_strobe;
  logic non_pcm_flag_pin, cd_sync_flag, auto_use_adc, adc_out_clock_sel, osc_run;
  logic buffered_crystal_clock_out;
  int miscompares = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'h1;
  logic [7:0] rv;
  logic [7:0] ra;
  logic [15:0] n;
  localparam logic [7:0] RST_VAL [7] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h03, 8'h0c, 8'hff};
  // limit setting, rate in 0.1 khz, expected error
  localparam logic [23:0] RATE_CASE [17] = '{24'h04_1e0_0, 24'h04_3c0_1, 24'h08_3c0_0,
    24'h08_780_1, 24'h0c_780_0, 24'h01_050_0, 24'h01_03c_1, 24'h02_06e_1, 24'h03_140_0,
    24'h03_0f0_1, 24'h10_1e0_0, 24'h10_1ea_1, 24'h10_500_0, 24'h90_500_1, 24'h50_280_1,
    24'h40_280_0, 24'h00_9c4_0};
  // definition setting, cs bit1 / burst levels, expected pin
  localparam logic [11:0] NON_PCM_FLAG_PIN_CASE [8] = '{12'h039, 12'h035, 12'h030, 12'h028, 12'h014,
    12'h138, 12'h131, 12'h238};

  always #4 clk = ~clk;

  ref_flag_logic DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .error_release_wait(error_release_wait),
    .pll_locked(pll_locked), .rate_changed(rate_changed), .rate_measure(rate_measure),
    .validity_flag(validity_flag), .parity_error(parity_error), .preamble_b(preamble_b),
    .cs_bit1_detect(cs_bit1_detect), .burst_preamble_detect(burst_preamble_detect),
    .sync_word16_detect(sync_word16_detect), .sync_word14_detect(sync_word14_detect),
    .sync_period_mark(sync_period_mark), .crystal_power_down(crystal_power_down),
    .xtal_tick(xtal_tick), .error_flag(error_flag), .clock_change_strobe(clock_change_strobe),
    .non_pcm_flag_pin(non_pcm_flag_pin), .cd_sync_flag(cd_sync_flag),
    .auto_use_adc(auto_use_adc), .adc_out_clock_sel(adc_out_clock_sel), .osc_run(osc_run),
    .buffered_crystal_clock_out(buffered_crystal_clock_out));

  ref_src_model src (.clk(clk), .rst(rst), .lock_req(lock_req), .osc_run(osc_run),
    .pll_locked(pll_locked), .preamble_b(preamble_b), .xtal_tick(xtal_tick));

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    xorshift = x ^ (x << 5);
  endfunction

  function automatic logic [7:0] reg_mask(input logic [7:0] a);
    case (a)
      8'h24: reg_mask = 8'h9c;
      8'h25: reg_mask = 8'h3f;
      8'h26, 8'h2a: reg_mask = 8'hff;
      8'h27: reg_mask = 8'hdf;
      8'h28: reg_mask = 8'h37;
      8'h29: reg_mask = 8'h0f;
      default: reg_mask = 8'h00;
    endcase
  endfunction

  function automatic int wait_count(input logic [1:0] c);
    wait_count = (c == 2'b00) ? 48 : (c == 2'b01) ? 12 : (c == 2'b10) ? 6 : 3;
  endfunction

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    cyc(2);
    d = reg_rdata;
  endtask

  // count preambles from the end of a cause until error release, and strobe release for an unlock cause
  task automatic release_run(input logic [1:0] code, input logic by_rate);
    int np = 0;
    int ne = -1;
    int ns = -1;
    int k;
    logic hi = 1'b0;
    @(posedge clk);
    error_release_wait <= code;
    if (by_rate) begin
      rate_changed <= 1'b1;
      @(posedge clk);
      rate_changed <= 1'b0;
    end else begin
      lock_req <= 1'b0;
      cyc(6);
      check(error_flag, 1'b1);
      check(auto_use_adc, 1'b1);
      @(posedge clk);
      lock_req <= 1'b1;
    end
    for (k = 0; k < 1000 && (ne < 0 || ns < 0); k++) begin
      cyc(1);
      if (preamble_b === 1'b1) np++;
      if (error_flag === 1'b1) hi = 1'b1;
      if (hi && ne < 0 && error_flag === 1'b0) ne = np;
      if (ns < 0 && (by_rate || clock_change_strobe === 1'b0)) ns = np;
    end
    if (k == 1000) miscompares++;
    check(16'(ne), 16'(wait_count(code)));
    if (!by_rate) check(16'(ns), 16'(wait_count(code)));
  endtask

  task automatic sync_pulse(input logic s16, input logic s14, output logic seen);
    seen = 1'b0;
    @(posedge clk);
    sync_word16_detect <= s16;
    sync_word14_detect <= s14;
    @(posedge clk);
    sync_word16_detect <= 1'b0;
    sync_word14_detect <= 1'b0;
    repeat (6) begin
      cyc(1);
      seen = seen | cd_sync_flag;
    end
  endtask

  // rising edges of the clock output over 128 cycles
  task automatic edges(output logic [15:0] cnt);
    logic prev;
    cnt = 16'h0;
    cyc(4);
    prev = buffered_crystal_clock_out;
    repeat (128) begin
      cyc(1);
      if (!prev && buffered_crystal_clock_out) cnt++;
      prev = buffered_crystal_clock_out;
    end
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(8'h24 + 8'(i), rv);
      check(rv, RST_VAL[i]);
    end
    wr(8'h2b, 8'hff);
    rd(8'h2b, rv);
    check(rv, 8'h00);
    // random writes with readback, unmapped address among them
    for (int i = 0; i < 24; i++) begin
      seed = xorshift(seed);
      ra = (seed[2:0] == 3'h7) ? 8'h30 : 8'h24 + {5'h0, seed[2:0]};
      @(posedge clk);
      sync_period_mark <= seed[16];
      wr(ra, seed[15:8]);
      sync_period_mark <= 1'b0;
      rd(ra, rv);
      check(rv, seed[15:8] & reg_mask(ra));
    end
    for (int i = 0; i < 7; i++) wr(8'h24 + 8'(i), RST_VAL[i]);
    for (int c = 0; c < 4; c++) release_run(2'(c), 1'b0);
    wr(8'h25, 8'h20);
    release_run(2'b11, 1'b1);
    // cause selection, error and auto kept apart
    wr(8'h25, 8'h02);
    @(posedge clk);
    parity_error <= 1'b1;
    cyc(3);
    check(error_flag, 1'b1);
    check(auto_use_adc, 1'b0);
    wr(8'h26, 8'h40);
    cyc(3);
    check(auto_use_adc, 1'b1);
    @(posedge clk);
    parity_error <= 1'b0;
    cyc(2);
    check(error_flag, 1'b0);
    wr(8'h25, 8'h01);
    wr(8'h26, 8'h84);
    @(posedge clk);
    validity_flag <= 1'b1;
    cyc(3);
    check(auto_use_adc, 1'b1);
    check(error_flag, 1'b0);
    check(adc_out_clock_sel, 1'b1);
    @(posedge clk);
    validity_flag <= 1'b0;
    wr(8'h26, 8'h10);
    cyc(2);
    check(adc_out_clock_sel, 1'b0);
    wr(8'h25, 8'h10);
    for (int i = 0; i < 17; i++) begin
      wr(8'h27, RATE_CASE[i][23:16]);
      rate_measure <= RATE_CASE[i][15:4];
      cyc(64);
      check(error_flag, RATE_CASE[i][0]);
      check(auto_use_adc, RATE_CASE[i][0]);
    end
    wr(8'h27, 8'h00);
    wr(8'h25, 8'h01);
    wr(8'h26, 8'h01);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      cs_bit1_detect <= 1'b0;
      burst_preamble_detect <= 1'b0;
      wr(8'h28, NON_PCM_FLAG_PIN_CASE[i][11:4]);
      @(posedge clk);
      cs_bit1_detect <= NON_PCM_FLAG_PIN_CASE[i][3];
      burst_preamble_detect <= NON_PCM_FLAG_PIN_CASE[i][2];
      cyc(10);
      check(non_pcm_flag_pin, NON_PCM_FLAG_PIN_CASE[i][0]);
    end
    @(posedge clk);
    cs_bit1_detect <= 1'b0;
    wr(8'h28, 8'h07);
    wr(8'h29, 8'h04);
    sync_pulse(1'b1, 1'b0, rv[0]);
    check(rv[0], 1'b0);
    wr(8'h29, 8'h08);
    sync_pulse(1'b0, 1'b1, rv[0]);
    check(rv[0], 1'b0);
    wr(8'h28, 8'h03);
    wr(8'h29, 8'h0c);
    sync_pulse(1'b1, 1'b0, rv[0]);
    check(rv[0], 1'b0);
    wr(8'h28, 8'h07);
    sync_pulse(1'b1, 1'b0, rv[0]);
    check(rv[0], 1'b1);
    // two periods needed, count cleared by unlock
    wr(8'h29, 8'h0e);
    @(posedge clk);
    lock_req <= 1'b0;
    cyc(4);
    @(posedge clk);
    lock_req <= 1'b1;
    sync_pulse(1'b1, 1'b0, rv[0]);
    check(rv[0], 1'b0);
    repeat (2) begin
      @(posedge clk);
      sync_period_mark <= 1'b1;
      @(posedge clk);
      sync_period_mark <= 1'b0;
    end
    sync_pulse(1'b0, 1'b1, rv[0]);
    check(rv[0], 1'b1);
    wr(8'h24, 8'h80);
    cyc(4);
    check(osc_run, 1'b0);
    @(posedge clk);
    lock_req <= 1'b0;
    cyc(4);
    check(osc_run, 1'b1);
    @(posedge clk);
    lock_req <= 1'b1;
    wr(8'h24, 8'h10);
    @(posedge clk);
    crystal_power_down <= 1'b1;
    cyc(4);
    check(osc_run, 1'b0);
    edges(n);
    check(n, 16'h0);
    @(posedge clk);
    crystal_power_down <= 1'b0;
    wr(8'h24, 8'h00);
    cyc(2);
    check(osc_run, 1'b1);
    edges(n);
    check(n, 16'h0);
    for (int d = 0; d < 4; d++) begin
      wr(8'h24, 8'h10 | 8'(d << 2));
      edges(n);
      check(n + 1 >= (64 >> d) && n <= (64 >> d) + 1, 1'b1);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
